// *** lsgp_cfg.svh ***
// Register map, field positions and reset values of the shared port block
`ifndef LSGP_CFG_SVH
`define LSGP_CFG_SVH
`define LSGP_ADDR_W 4
`define LSGP_OFF_SEG_DATA 4'h0
`define LSGP_OFF_SEG_DIR 4'h4
`define LSGP_OFF_SUP_DATA 4'h8
`define LSGP_OFF_SUP_DIR 4'hC
`define LSGP_OFF_CTRL 4'h1
`define LSGP_OFF_MODIFY_DATA_SEG 4'h2
`define LSGP_OFF_MODIFY_DATA_SUP 4'h3
`define LSGP_DIR_RST 8'h00
`define LSGP_DATA_RST 8'h00
`define LSGP_CTRL_RST 16'h0000
`define LSGP_SEG_W 8
`define LSGP_SUP_W 5
`define LSGP_CTRL_SEG_LSB 0
`define LSGP_CTRL_SUP_LSB 8
`define LSGP_CTRL_PORT_IN_CTL_BIT 13
`define LSGP_CTRL_SPS_BIT 14
`define LSGP_RD_UNMAPPED 32'h0000_0000
`endif

// *** lsgp_pkg.sv ***
// Types shared by the shared port block
package lsgp_pkg;
  typedef enum logic [1:0] {
    LSGP_IDLE = 2'b01,
    LSGP_ANS = 2'b10
  } lsgp_bus_e;
endpackage

// *** lsgp_ports.sv ***
// Two general purpose ports sharing pins with LCD segment and supply functions
// What this block does
// [RULE1] Direction one drives data latch onto pin; code drives segment pins only while the port input control bit is set
// [RULE2] Direction zero makes pin an input
// [RULE3] Data write updates latch, output pins follow
// [RULE4] Input pins keep latch value, not driven
// [RULE5] Output pins read back latch value
// [RULE6] Input pins read pin; modify-write reads latch
// [RULE7] Reset clears all direction bits
// [RULE8] Standby with pin-state one floats and blocks
// [RULE9] Standby with pin-state zero changes nothing
// [RULE10] Segment select zero gives port operation; code drives such pins only while the port input control bit is set
// [RULE11] Segment select one routes LCD segment; code routes it only while the port input control bit is set
// [RULE12] Software clears direction for segment pins
// [RULE13] Supply enable zero gives port operation
// [RULE14] Supply enable one selects LCD supply use
// [RULE15] Eight-pin port bits map to pins
// [RULE16] Five-pin port implements bits zero to four
// [RULE17] Software disables peripheral outputs first
// [RULE18] Absent upper bits read zero
`timescale 1ns/1ps
`include "lsgp_cfg.svh"
module lsgp_ports
  import lsgp_pkg::*;
#(
  parameter int SEG_W = `LSGP_SEG_W,
  parameter int SUP_W = `LSGP_SUP_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [`LSGP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic standby_enter,
  input wire logic [SEG_W-1:0] lcd_seg_drive,
  input wire logic [SEG_W-1:0] seg_pin_i,
  output logic [SEG_W-1:0] seg_pin_o,
  output logic [SEG_W-1:0] seg_pin_oe,
  output logic [SEG_W-1:0] seg_in_blocked,
  input wire logic [SUP_W-1:0] sup_pin_i,
  output logic [SUP_W-1:0] sup_pin_o,
  output logic [SUP_W-1:0] sup_pin_oe,
  output logic [SUP_W-1:0] sup_lcd_supply_sel
);
  // ****************************************
  // Registers
  // ****************************************
  logic [SEG_W-1:0] seg_data_r;
  logic [SEG_W-1:0] seg_dir_r;
  logic [SUP_W-1:0] sup_data_r;
  logic [SUP_W-1:0] sup_dir_r;
  logic [SEG_W-1:0] segment_select_r;
  logic [SUP_W-1:0] lcd_supply_enable_r;
  logic port_input_control_r;
  logic standby_pin_state_r;
  logic [SEG_W-1:0] seg_s1_r, seg_s2_r;
  logic [SUP_W-1:0] sup_s1_r, sup_s2_r;
  lsgp_bus_e bus_r;
  logic [31:0] rdata_r;

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic hit(input logic [`LSGP_ADDR_W-1:0] a, input logic [`LSGP_ADDR_W-1:0] o);
    hit = (a == o);
  endfunction

  wire take = (bus_r == LSGP_IDLE) && (avs_read || avs_write);
  // Writes land at the edge where the master sees waitrequest low, never earlier
  wire ans = (bus_r == LSGP_ANS);
  wire wr = ans && avs_write && avs_byteenable[0];
  wire wr_hi = ans && avs_write && avs_byteenable[1];
  wire wr_seg_data = wr && hit(avs_address, `LSGP_OFF_SEG_DATA); // [RULE3] [RULE4]
  wire wr_seg_dir = wr && hit(avs_address, `LSGP_OFF_SEG_DIR);
  wire wr_sup_data = wr && hit(avs_address, `LSGP_OFF_SUP_DATA);
  wire wr_sup_dir = wr && hit(avs_address, `LSGP_OFF_SUP_DIR);
  wire wr_ctrl = wr && hit(avs_address, `LSGP_OFF_CTRL);
  wire wr_ctrl_hi = wr_hi && hit(avs_address, `LSGP_OFF_CTRL);

  // Standby floats pins only while the pin-state bit is set
  wire float_all = standby_enter && standby_pin_state_r; // [RULE8] [RULE9]

  // Synchronised pins forced low while blocked, to avoid open-input leakage
  wire [SEG_W-1:0] seg_in = float_all ? '0 : seg_s2_r; // [RULE8]
  wire [SUP_W-1:0] sup_in = float_all ? '0 : sup_s2_r;

  // Normal read mixes latch and pin per direction; modify-write reads latch
  wire [SEG_W-1:0] seg_rd = (seg_dir_r & seg_data_r) | (~seg_dir_r & seg_in); // [RULE5] [RULE6]
  wire [SUP_W-1:0] sup_rd = (sup_dir_r & sup_data_r) | (~sup_dir_r & sup_in);

  wire [31:0] ctrl_rd = {17'h0_0000, standby_pin_state_r, port_input_control_r,
                         lcd_supply_enable_r, segment_select_r};

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = `LSGP_RD_UNMAPPED;
    case (avs_address)
      `LSGP_OFF_SEG_DATA: rd_mux = {24'h00_0000, seg_rd};
      `LSGP_OFF_SEG_DIR: rd_mux = {24'h00_0000, seg_dir_r};
      `LSGP_OFF_SUP_DATA: rd_mux = {27'h000_0000, sup_rd}; // [RULE18]
      `LSGP_OFF_SUP_DIR: rd_mux = {27'h000_0000, sup_dir_r};
      `LSGP_OFF_CTRL: rd_mux = ctrl_rd;
      `LSGP_OFF_MODIFY_DATA_SEG: rd_mux = {24'h00_0000, seg_data_r}; // [RULE6]
      `LSGP_OFF_MODIFY_DATA_SUP: rd_mux = {27'h000_0000, sup_data_r};
      default: rd_mux = `LSGP_RD_UNMAPPED;
    endcase
  end

  // ****************************************
  // Bus slave: one wait cycle, answer on the second edge
  // ****************************************
  lsgp_bus_e bus_nxt;
  always_comb begin
    case (bus_r)
      LSGP_IDLE: bus_nxt = take ? LSGP_ANS : LSGP_IDLE;
      LSGP_ANS: bus_nxt = LSGP_IDLE;
      default: bus_nxt = LSGP_IDLE;
    endcase
  end
  assign avs_waitrequest = (avs_read || avs_write) && (bus_r != LSGP_ANS);
  assign avs_readdata = rdata_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_r <= LSGP_IDLE;
      rdata_r <= `LSGP_RD_UNMAPPED;
    end else begin
      bus_r <= bus_nxt;
      if (take && avs_read) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Pin synchronisers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      seg_s1_r <= '0;
      seg_s2_r <= '0;
      sup_s1_r <= '0;
      sup_s2_r <= '0;
    end else begin
      seg_s1_r <= seg_pin_i;
      seg_s2_r <= seg_s1_r;
      sup_s1_r <= sup_pin_i;
      sup_s2_r <= sup_s1_r;
    end
  end

  // Port registers; writes land at the answer edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      seg_dir_r <= SEG_W'(`LSGP_DIR_RST); // [RULE7]
      sup_dir_r <= SUP_W'(`LSGP_DIR_RST); // [RULE7]
      seg_data_r <= SEG_W'(`LSGP_DATA_RST);
      sup_data_r <= SUP_W'(`LSGP_DATA_RST);
    end else begin
      if (wr_seg_data) seg_data_r <= avs_writedata[SEG_W-1:0]; // [RULE15]
      if (wr_seg_dir) seg_dir_r <= avs_writedata[SEG_W-1:0];
      if (wr_sup_data) sup_data_r <= avs_writedata[SUP_W-1:0]; // [RULE16]
      if (wr_sup_dir) sup_dir_r <= avs_writedata[SUP_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      segment_select_r <= '0;
      lcd_supply_enable_r <= '0;
      port_input_control_r <= 1'b0;
      standby_pin_state_r <= 1'b0;
    end else begin
      if (wr_ctrl) segment_select_r <= avs_writedata[`LSGP_CTRL_SEG_LSB +: SEG_W];
      if (wr_ctrl_hi) begin
        lcd_supply_enable_r <= avs_writedata[`LSGP_CTRL_SUP_LSB +: SUP_W];
        port_input_control_r <= avs_writedata[`LSGP_CTRL_PORT_IN_CTL_BIT];
        standby_pin_state_r <= avs_writedata[`LSGP_CTRL_SPS_BIT];
      end
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Until the port input control bit is set neither function reaches a segment pin
  wire [SEG_W-1:0] seg_lcd = segment_select_r & {SEG_W{port_input_control_r}}; // [RULE11]
  wire [SEG_W-1:0] seg_gpio = ~segment_select_r & {SEG_W{port_input_control_r}}; // [RULE10]
  assign seg_pin_o = (seg_lcd & lcd_seg_drive) | (~seg_lcd & seg_data_r); // [RULE1] [RULE3]
  assign seg_pin_oe = float_all ? '0 : (seg_lcd | (seg_gpio & seg_dir_r)); // [RULE1] [RULE2] [RULE8]
  assign seg_in_blocked = {SEG_W{float_all}};
  assign sup_lcd_supply_sel = lcd_supply_enable_r; // [RULE14]
  assign sup_pin_o = sup_data_r;
  // Supply pins never driven while used as LCD supply inputs
  assign sup_pin_oe = float_all ? '0 : (~lcd_supply_enable_r & sup_dir_r); // [RULE13] [RULE4]

  // ****************************************
  // Checks
  // ****************************************
  chk_float_pins: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE8]
    (standby_enter && standby_pin_state_r) |-> (seg_pin_oe == '0 && sup_pin_oe == '0))
    else $error("pins driven in floating standby");
  chk_out_latch: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE1]
    (!float_all && port_input_control_r) |-> ((seg_pin_oe & ~segment_select_r) ==
      (seg_dir_r & ~segment_select_r)) && ((seg_pin_o & seg_gpio) == (seg_data_r & seg_gpio)))
    else $error("output pin not following latch");
  chk_in_undriven: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE2]
    ((sup_pin_oe & ~sup_dir_r) == '0))
    else $error("input pin driven");
  chk_write_latch: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE3]
    wr_seg_data |=> seg_data_r == $past(avs_writedata[SEG_W-1:0]))
    else $error("data write lost");
  chk_read_mix: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE5]
    (take && avs_read && avs_address == `LSGP_OFF_SEG_DATA) |=>
      (rdata_r[SEG_W-1:0] & $past(seg_dir_r)) == ($past(seg_data_r) & $past(seg_dir_r)))
    else $error("read of output pins not latch");
  chk_rmw_read: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE6]
    (take && avs_read && avs_address == `LSGP_OFF_MODIFY_DATA_SUP) |=>
      rdata_r == {27'h000_0000, $past(sup_data_r)})
    else $error("modify-write read not latch");
  chk_upper_zero: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE18]
    (ans && avs_read && avs_address == `LSGP_OFF_SUP_DIR) |-> avs_readdata[31:SUP_W] == '0)
    else $error("absent bits not zero");
  chk_reset_dir: assert property (@(posedge mclk) // [RULE7]
    $past(sys_rst) |-> (seg_dir_r == '0 && sup_dir_r == '0))
    else $error("direction not cleared by reset");
  chk_supply_sel: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE14]
    ((sup_pin_oe & lcd_supply_enable_r) == '0))
    else $error("supply pin driven");
  chk_answer_time: assert property (@(posedge mclk) disable iff (sys_rst)
    take |=> !avs_waitrequest)
    else $error("answer late");
  chk_seg_in_undriven: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE2]
    ((seg_pin_oe & seg_gpio & ~seg_dir_r) == '0))
    else $error("segment input pin driven");
  chk_port_sel: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE10]
    !float_all |-> ((seg_pin_oe & seg_gpio) == (seg_dir_r & seg_gpio)))
    else $error("port pin direction not followed");
  chk_lcd_route: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE11]
    ((seg_lcd & (seg_pin_o ^ lcd_seg_drive)) == '0))
    else $error("segment level not routed");
  chk_sup_port: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE13]
    !float_all |-> ((sup_pin_oe & ~lcd_supply_enable_r) == (sup_dir_r & ~lcd_supply_enable_r)))
    else $error("supply port direction not followed");
  chk_hold_standby: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE9]
    (standby_enter && !standby_pin_state_r) |-> (sup_pin_oe == (~lcd_supply_enable_r & sup_dir_r)))
    else $error("standby changed pin drive");
  chk_blocked_in: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE8]
    float_all |-> (seg_in_blocked == '1 && seg_in == '0 && sup_in == '0))
    else $error("input not blocked low");
  cov_seg_lcd: cover property (@(posedge mclk) disable iff (sys_rst) |seg_lcd);
  cov_float: cover property (@(posedge mclk) disable iff (sys_rst) float_all);
  cov_rd: cover property (@(posedge mclk) disable iff (sys_rst) take && avs_read);
  cov_wr_dir: cover property (@(posedge mclk) disable iff (sys_rst) wr_sup_dir);
  cov_modify_rd: cover property (@(posedge mclk) disable iff (sys_rst)
    take && avs_read && avs_address == `LSGP_OFF_MODIFY_DATA_SEG);
endmodule

// *** lsgp_pin_model.sv ***
// Board side model of the shared port pins
`timescale 1ns/1ps
module lsgp_pin_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pin_o,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] ext,
  output logic [W-1:0] lvl
);
  // Released pins show the board level, reseeded every step so no stale value lingers
  assign lvl = (pin_o & pin_oe) | (ext & ~pin_oe);
endmodule

// *** tb_lcd_shared_gpio_ports.sv ***
// Self-checking bench of the shared port block
`timescale 1ns/1ps
module tb_lcd_shared_gpio_ports
  import lsgp_pkg::*;
;
  logic mclk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, standby_enter = 0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q, r;
  logic avs_waitrequest, pin_ctl, pin_state, fl;
  logic [7:0] lcd = 8'h00, sext = 8'h00, sd, sdir, sel, seg_i, seg_o, seg_oe, blk, eo, eoe, sp;
  logic [4:0] pext = 5'h00, pd, pdir, en, sup_i, sup_o, sup_oe, ssel, poe, pp;
  int n_mismatch = 0, num_checks = 0;
  initial forever #2.5 mclk = ~mclk;
  lsgp_ports dut_u (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .standby_enter(standby_enter), .lcd_seg_drive(lcd),
    .seg_pin_i(seg_i), .seg_pin_o(seg_o), .seg_pin_oe(seg_oe), .seg_in_blocked(blk),
    .sup_pin_i(sup_i), .sup_pin_o(sup_o), .sup_pin_oe(sup_oe), .sup_lcd_supply_sel(ssel));
  lsgp_pin_model #(.W(8)) seg_pins (.pin_o(seg_o), .pin_oe(seg_oe), .ext(sext), .lvl(seg_i));
  lsgp_pin_model #(.W(5)) sup_pins (.pin_o(sup_o), .pin_oe(sup_oe), .ext(pext), .lvl(sup_i));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Request held until waitrequest is seen low, then taken and released at that edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(negedge mclk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) n_mismatch++;
    @(posedge mclk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task finish_test;
    if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
  // ********************
  // Test sequence
  // ********************
  initial begin
    void'($urandom(98644));
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(4'h4, 32'h0000_0000);
    rd(4'hC, 32'h0000_0000);
    rd(4'h5, 32'h0000_0000);
    repeat (40) begin
      sel = 8'($urandom);
      en = 5'($urandom);
      pin_state = 1'($urandom);
      pin_ctl = 1'($urandom);
      sd = 8'($urandom);
      sdir = 8'($urandom) & ~sel;
      bus(1'b1, 4'h1, {17'h0_0000, pin_state, 1'b0, en, sel});
      bus(1'b1, 4'h1, {17'h0_0000, pin_state, pin_ctl, en, sel});
      bus(1'b1, 4'h0, {24'h00_0000, sd});
      bus(1'b1, 4'h4, {24'h00_0000, sdir});
      r = $urandom;
      pd = r[4:0];
      bus(1'b1, 4'h8, r);
      r = $urandom;
      pdir = r[4:0] & ~en;
      bus(1'b1, 4'hC, {r[31:5], pdir});
      @(posedge mclk);
      {lcd, sext, pext, standby_enter} <= 22'($urandom);
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      fl = standby_enter & pin_state;
      eoe = (fl | !pin_ctl) ? 8'h00 : (sel | sdir);
      eo = (sel & lcd) | (~sel & sd);
      sp = (eo & eoe) | (sext & ~eoe);
      poe = fl ? 5'h00 : (pdir & ~en);
      pp = (pd & poe) | (pext & ~poe);
      chk({24'h00_0000, seg_oe}, {24'h00_0000, eoe});
      chk({24'h00_0000, seg_o & eoe}, {24'h00_0000, eo & eoe});
      chk({24'h00_0000, blk}, fl ? 32'h0000_00FF : 32'h0000_0000);
      chk({27'h000_0000, sup_oe}, {27'h000_0000, poe});
      chk({27'h000_0000, sup_o & poe}, {27'h000_0000, pd & poe});
      chk({27'h000_0000, ssel}, {27'h000_0000, en});
      rd(4'h0, {24'h00_0000, (sdir & sd) | (~sdir & (fl ? 8'h00 : sp))});
      rd(4'h2, {24'h00_0000, sd});
      rd(4'h8, {27'h000_0000, (pdir & pd) | (~pdir & (fl ? 5'h00 : pp))});
      rd(4'h3, {27'h000_0000, pd});
      rd(4'h4, {24'h00_0000, sdir});
      rd(4'hC, {27'h000_0000, pdir});
    end
    finish_test();
  end
endmodule
